/* core/aepu_pkg.sv */
// aepu_pkg: shared types and constants of the operand-extension prefix unit
// assumes one core clock; decode hands in one-cycle instruction strobes
package aepu_pkg;
  localparam int unsigned EXT_W          = 8;
  localparam logic [7:0]  EXT_RESET      = 8'h00;   // content undefined, zero chosen
  localparam logic [3:0]  FLAG_RESET     = 4'h0;
  localparam int unsigned FLAG_Z_BIT     = 0;
  localparam int unsigned FLAG_C_BIT     = 1;
  localparam int unsigned FLAG_I_BIT     = 2;
  localparam int unsigned FLAG_E_BIT     = 3;
  localparam logic [15:0] X_PAGE_BASE    = 16'h0000;
  localparam logic [15:0] Y_PAGE_BASE    = 16'hFF00;
  localparam logic [7:0]  CMP_HIGH_ALL   = 8'hFF;

  typedef enum logic [3:0] {
    AEPU_OP_NONE,
    AEPU_OP_EXT_LOAD_IMM,   // load_byte_op into extension_byte_reg, immediate_byte
    AEPU_OP_EXT_LOAD_BA,    // load_byte_op into extension_byte_reg, byte_accumulator_pair
    AEPU_OP_EXT_READ,       // load_byte_op extension_byte_reg to byte_accumulator_pair
    AEPU_OP_FLAG_LOAD_A,    // whole flag write from accumulator_low
    AEPU_OP_FLAG_LOAD_IMM,
    AEPU_OP_FLAG_AND,
    AEPU_OP_FLAG_OR,
    AEPU_OP_FLAG_XOR,
    AEPU_OP_FLAG_RESTORE,   // interrupt_return_op or flag pop
    AEPU_OP_OTHER           // any other executed instruction
  } aepu_op_t;

  typedef enum logic [2:0] {
    AEPU_OPD_NONE,
    AEPU_OPD_X_INDIRECT,    // 4-bit access through first index
    AEPU_OPD_Y_INDIRECT,    // 4-bit access through second index
    AEPU_OPD_INDEX_LOAD,    // index low byte load
    AEPU_OPD_INDEX_ADD,     // index add signed_byte_offset
    AEPU_OPD_INDEX_CMP,     // compare_op on index
    AEPU_OPD_REL_BRANCH     // relative jumps, conditional forms, relative_call_op
  } aepu_opd_t;

  typedef struct packed {
    logic       valid;      // one-cycle strobe: instruction executes now
    aepu_op_t   op;
    aepu_opd_t  opd;
    logic [7:0] operand;    // immediate_byte or signed_byte_offset
    logic [7:0] ba;         // byte_accumulator_pair
    logic [3:0] a_low;      // accumulator_low / imm4 for flag ops
    logic [3:0] flag_data;  // restored flag image
    logic [15:0] index;     // current index register value
  } aepu_exec_t;

  typedef struct packed {
    logic        valid;
    logic        extended;  // extension applied to this instruction
    logic [15:0] value;     // widened operand, address or displacement
    logic [7:0]  ba_read;   // extension_byte_reg copy for read form
  } aepu_result_t;
endpackage

/* core/aepu_widen.sv */
// aepu_widen: combinational operand widening for the executing instruction
// assumes its output is registered by the caller
`timescale 1ns/10ps
`default_nettype none
module aepu_widen (
  input  wire aepu_pkg::aepu_opd_t opd_i,
  input  wire logic [7:0]          operand_i,
  input  wire logic [7:0]          ext_i,
  input  wire logic                ext_on_i,
  input  wire logic [15:0]         index_i,
  output logic [15:0]              value_o
);
  import aepu_pkg::*;

  // extension supplies high byte (low byte behind the page base for indirect); otherwise index or 8-bit forms
  always_comb begin
    value_o = {8'h00, operand_i};
    unique case (opd_i)
      AEPU_OPD_NONE:       value_o = {8'h00, operand_i};
      AEPU_OPD_X_INDIRECT: value_o = ext_on_i ? (X_PAGE_BASE | {8'h00, ext_i}) : index_i;
      AEPU_OPD_Y_INDIRECT: value_o = ext_on_i ? (Y_PAGE_BASE | {8'h00, ext_i}) : index_i;
      AEPU_OPD_INDEX_LOAD: value_o = ext_on_i ? {ext_i, operand_i}
                                              : {index_i[15:8], operand_i};
      AEPU_OPD_INDEX_ADD:  value_o = ext_on_i ? {ext_i, operand_i}
                                              : {{8{operand_i[7]}}, operand_i};
      // compare subtracts the complement: high byte is FFH minus extension
      AEPU_OPD_INDEX_CMP:  value_o = ext_on_i ? {CMP_HIGH_ALL - ext_i, operand_i}
                                              : {8'h00, operand_i};
      // signed displacement, -128..+127 plain, full 16-bit extended
      AEPU_OPD_REL_BRANCH: value_o = ext_on_i ? {ext_i, operand_i}
                                              : {{8{operand_i[7]}}, operand_i};
      default:             value_o = {8'h00, operand_i};
    endcase
  end
endmodule
`default_nettype wire

/* core/aepu_top.sv */
// aepu_top: extension register, extension-valid flag and interrupt hold-off
// assumes decode presents one executing instruction per valid strobe
// assumes flag arithmetic and interrupt entry arrive as one-cycle pulses
// assumes the index value on exec_i is the register named by the operand
`timescale 1ns/10ps
`default_nettype none
module aepu_top (
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire aepu_pkg::aepu_exec_t  exec_i,
  input  wire logic                  irq_pending_i,  // any interrupt incl. nonmaskable
  input  wire logic                  flag_zc_we_i,   // arithmetic update of zero/carry
  input  wire logic [1:0]            flag_zc_i,
  input  wire logic                  irq_entry_i,    // core enters interrupt: clears I
  output aepu_pkg::aepu_result_t     result_o,
  output logic [3:0]                 flag_o,
  output logic                       irq_accept_o
);
  import aepu_pkg::*;

  logic [7:0]   ext_q, ext_d;
  logic [3:0]   flag_q, flag_d;
  logic         hold_q, hold_d;
  logic         accept_q, accept_d;
  aepu_result_t res_q, res_d;
  logic [15:0]  wide_value;
  logic         ext_on;
  logic         ext_write;
  logic         flag_write;
  logic         read_op;
  logic         ext_capable;
  logic [3:0]   flag_op_val;

  // the flag in effect for the executing instruction is the stored E bit
  assign ext_on = flag_q[FLAG_E_BIT];

  // only operand kinds that take the extension may report it
  assign ext_capable = exec_i.opd != AEPU_OPD_NONE;

  // decode of the executing instruction into register actions
  always_comb begin
    ext_write  = 1'b0;
    flag_write = 1'b0;
    read_op    = 1'b0;
    if (exec_i.valid) begin
      unique case (exec_i.op)
        AEPU_OP_EXT_LOAD_IMM,
        AEPU_OP_EXT_LOAD_BA:   ext_write  = 1'b1;
        AEPU_OP_FLAG_LOAD_A,
        AEPU_OP_FLAG_LOAD_IMM,
        AEPU_OP_FLAG_AND,
        AEPU_OP_FLAG_OR,
        AEPU_OP_FLAG_XOR,
        AEPU_OP_FLAG_RESTORE:  flag_write = 1'b1;
        AEPU_OP_EXT_READ:      read_op    = 1'b1;
        AEPU_OP_NONE,
        AEPU_OP_OTHER:         ;
        // unused codes raise no write or read action; E is still consumed
        default:               ;
      endcase
    end
  end

  // widening is combinational; the result register captures it
  aepu_widen u_widen (
    .opd_i     (exec_i.opd),
    .operand_i (exec_i.operand),
    .ext_i     (ext_q),
    .ext_on_i  (ext_on),
    .index_i   (exec_i.index),
    .value_o   (wide_value)
  );

  // extension register next value; it survives the flag clearing
  always_comb begin
    ext_d = ext_q;
    if (ext_write) begin
      unique case (exec_i.op)
        AEPU_OP_EXT_LOAD_IMM: ext_d = exec_i.operand;
        AEPU_OP_EXT_LOAD_BA:  ext_d = exec_i.ba;
        default:              ext_d = ext_q;
      endcase
    end
  end

  // value a flag instruction writes; whole writes take a_low as imm4 or A
  always_comb begin
    flag_op_val = flag_q;
    unique case (exec_i.op)
      AEPU_OP_FLAG_LOAD_A:   flag_op_val = exec_i.a_low;
      AEPU_OP_FLAG_LOAD_IMM: flag_op_val = exec_i.a_low;
      AEPU_OP_FLAG_AND:      flag_op_val = flag_q & exec_i.a_low;
      AEPU_OP_FLAG_OR:       flag_op_val = flag_q | exec_i.a_low;
      AEPU_OP_FLAG_XOR:      flag_op_val = flag_q ^ exec_i.a_low;
      AEPU_OP_FLAG_RESTORE:  flag_op_val = exec_i.flag_data;
      default:               flag_op_val = flag_q;
    endcase
  end

  // flag register next value; the executing instruction consumes E
  always_comb begin
    flag_d = flag_q;
    if (exec_i.valid) begin
      flag_d[FLAG_E_BIT] = 1'b0;
    end
    // arithmetic and interrupt entry touch only Z, C and I
    if (flag_zc_we_i) begin
      flag_d[FLAG_C_BIT] = flag_zc_i[1];
      flag_d[FLAG_Z_BIT] = flag_zc_i[0];
    end
    if (irq_entry_i) begin
      flag_d[FLAG_I_BIT] = 1'b0;
    end
    // a prefix load sets E after the auto clear, so the set wins
    if (ext_write) begin
      flag_d[FLAG_E_BIT] = 1'b1;
    end else if (flag_write) begin
      flag_d = flag_op_val;
    end
  end

  // interrupt hold-off: a prefix write blocks acceptance for one instruction
  always_comb begin
    hold_d = hold_q;
    if (exec_i.valid) begin
      // only a prefix or flag write holds the next instruction
      hold_d = ext_write || flag_write;
    end
  end

  // never accept while the extension is pending, so the saved E stays clear
  always_comb begin
    accept_d = 1'b0;
    if (irq_pending_i && !hold_q && !flag_q[FLAG_E_BIT]) begin
      accept_d = !ext_write && !flag_write;
    end
  end

  // result of the executing instruction; the read copy holds between reads
  always_comb begin
    res_d          = '0;
    res_d.valid    = exec_i.valid;
    if (exec_i.valid) begin
      res_d.extended = ext_on && ext_capable;
    end
    res_d.value    = wide_value;
    res_d.ba_read  = read_op ? ext_q : res_q.ba_read;
  end

  // extension register; content is undefined to software, cleared for determinism
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ext_q <= EXT_RESET;
    end else begin
      ext_q <= ext_d;
    end
  end

  // flag register; E starts clear so the first instruction is never extended
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_q <= FLAG_RESET;
    end else begin
      flag_q <= flag_d;
    end
  end

  // interrupt hold-off state
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
    end
  end

  // interrupt accept level
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      accept_q <= 1'b0;
    end else begin
      accept_q <= accept_d;
    end
  end

  // result register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      res_q <= '0;
    end else begin
      res_q <= res_d;
    end
  end

  // outputs come straight from their registers
  assign result_o     = res_q;
  assign flag_o       = flag_q;
  assign irq_accept_o = accept_q;
endmodule
`default_nettype wire

/* sim/aepu_top_monitor.sv */
// aepu_top_monitor: timing relations of the extension prefix unit
// assumes it is bound into aepu_top and sees its ports only
`timescale 1ns/10ps
`default_nettype none
module aepu_top_monitor (
  input wire logic                 clk_i,
  input wire logic                 reset_n_i,
  input wire aepu_pkg::aepu_exec_t exec_i,
  input wire aepu_pkg::aepu_result_t result_o,
  input wire logic [3:0]           flag_o,
  input wire logic                 irq_accept_o
);
  import aepu_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [7:0] ext_q;
  logic       use_e;
  // shadow of the extension byte, needed since it has no port
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) ext_q <= EXT_RESET;
    else if (exec_i.valid && exec_i.op == AEPU_OP_EXT_LOAD_IMM) ext_q <= exec_i.operand;
    else if (exec_i.valid && exec_i.op == AEPU_OP_EXT_LOAD_BA) ext_q <= exec_i.ba;
  end
  assign use_e = flag_o[FLAG_E_BIT] && exec_i.valid && exec_i.op == AEPU_OP_OTHER;
  // load, then the one instruction that consumes it
  sequence s_load;
    exec_i.valid && exec_i.op inside {AEPU_OP_EXT_LOAD_IMM, AEPU_OP_EXT_LOAD_BA};
  endsequence
  sequence s_load_use;
    s_load ##1 use_e;
  endsequence
  a_load_sets_e: assert property (s_load |=> flag_o[FLAG_E_BIT])
    else $error("load left E clear");
  a_one_shot: assert property (s_load_use |=> !flag_o[FLAG_E_BIT])
    else $error("E still set");
  a_high_byte: assert property (use_e && exec_i.opd inside {AEPU_OPD_INDEX_LOAD,
    AEPU_OPD_INDEX_ADD, AEPU_OPD_REL_BRANCH} |=> result_o.extended
    && result_o.value == {$past(ext_q), $past(exec_i.operand)}) else $error("bad widen");
  a_page_base: assert property (use_e && exec_i.opd inside {AEPU_OPD_X_INDIRECT,
    AEPU_OPD_Y_INDIRECT} |=> result_o.value == (($past(exec_i.opd) == AEPU_OPD_X_INDIRECT
    ? X_PAGE_BASE : Y_PAGE_BASE) | {8'h00, $past(ext_q)})) else $error("bad page");
  a_cmp_compl: assert property (use_e && exec_i.opd == AEPU_OPD_INDEX_CMP |=>
    result_o.value == {CMP_HIGH_ALL - $past(ext_q), $past(exec_i.operand)}) else $error("cmp");
  a_plain_branch: assert property (exec_i.valid && !flag_o[FLAG_E_BIT]
    && exec_i.opd == AEPU_OPD_REL_BRANCH |=> !result_o.extended && result_o.value
    == {{8{$past(exec_i.operand[7])}}, $past(exec_i.operand)}) else $error("short branch");
  a_irq_hold: assert property (exec_i.valid && exec_i.op inside {AEPU_OP_EXT_LOAD_IMM,
    AEPU_OP_EXT_LOAD_BA, AEPU_OP_FLAG_LOAD_A, AEPU_OP_FLAG_LOAD_IMM, AEPU_OP_FLAG_AND,
    AEPU_OP_FLAG_OR, AEPU_OP_FLAG_XOR} |=> !irq_accept_o) else $error("irq not held");
  a_ext_read: assert property (exec_i.valid && exec_i.op == AEPU_OP_EXT_READ |=>
    result_o.valid && result_o.ba_read == $past(ext_q)) else $error("bad read");
  a_restore_e: assert property (exec_i.valid && exec_i.op == AEPU_OP_FLAG_RESTORE |=>
    flag_o[FLAG_E_BIT] == $past(exec_i.flag_data[FLAG_E_BIT])) else $error("bad restore");
  a_reset_clear: assert property (!$past(reset_n_i) |-> flag_o == FLAG_RESET)
    else $error("flags not cleared");
endmodule
bind aepu_top aepu_top_monitor u_mon (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .exec_i(exec_i), .result_o(result_o), .flag_o(flag_o), .irq_accept_o(irq_accept_o));
`default_nettype wire

/* sim/aepu_top_tb.sv */
// aepu_top_tb: random and corner tests of the extension prefix unit
// assumes aepu_pkg and aepu_top are compiled before it
`timescale 1ns/10ps
`default_nettype none
module aepu_top_tb;
  import aepu_pkg::*;
  logic         clk_i = 1'b0;
  logic         reset_n_i = 1'b0;
  aepu_exec_t   ex = '0;
  logic [4:0]   side = 5'h00;  // random flag and interrupt inputs
  aepu_result_t res;
  logic [3:0]   flg;
  logic         acc;
  logic [7:0]   ext_m = EXT_RESET;
  logic [7:0]   rd_m = 8'h00;
  int           n_fail = 0;
  int           total_checks = 0;
  // prefix kinds; the last two leave the flag clear
  aepu_op_t     kind [9] = '{AEPU_OP_EXT_LOAD_IMM, AEPU_OP_EXT_LOAD_BA, AEPU_OP_FLAG_LOAD_A,
    AEPU_OP_FLAG_LOAD_IMM, AEPU_OP_FLAG_OR, AEPU_OP_FLAG_XOR, AEPU_OP_FLAG_RESTORE,
    AEPU_OP_FLAG_AND, AEPU_OP_NONE};
  always #5 clk_i = ~clk_i;
  aepu_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .exec_i(ex), .irq_pending_i(side[3]),
    .flag_zc_we_i(side[0]), .flag_zc_i(side[2:1]), .irq_entry_i(side[4]), .result_o(res),
    .flag_o(flg), .irq_accept_o(acc));
  function automatic aepu_exec_t mk(aepu_op_t op, aepu_opd_t od, logic [7:0] p, logic [7:0] b,
    logic [3:0] al, logic [3:0] fd, logic [15:0] ix);
    return '{1'b1, op, od, p, b, al, fd, ix};
  endfunction
  // expected widened value; unextended compare carries the bare immediate
  function automatic logic [15:0] wid(aepu_opd_t o, logic [7:0] p, logic [7:0] e, logic on,
    logic [15:0] ix);
    case (o)
      AEPU_OPD_X_INDIRECT: return on ? (X_PAGE_BASE | {8'h00, e}) : ix;
      AEPU_OPD_Y_INDIRECT: return on ? (Y_PAGE_BASE | {8'h00, e}) : ix;
      AEPU_OPD_INDEX_LOAD: return {on ? e : ix[15:8], p};
      AEPU_OPD_INDEX_CMP:  return on ? {CMP_HIGH_ALL - e, p} : {8'h00, p};
      default:             return on ? {e, p} : {{8{p[7]}}, p};
    endcase
  endfunction
  task automatic iss(input aepu_exec_t e);
    @(posedge clk_i);
    ex <= e;
    side <= 5'($urandom);
  endtask
  // result, consumed E and interrupt accept; a enables the pending level
  task automatic chk(input logic [15:0] v, input logic x, input logic a);
    logic [27:0] got;
    logic [27:0] want;
    @(posedge clk_i);
    ex.valid <= 1'b0;
    #1;
    got = {res.valid, res.extended, res.value, res.ba_read, flg[FLAG_E_BIT], acc};
    want = {1'b1, x, v, rd_m, 1'b0, a && side[3]};
    total_checks++;
    if (got !== want) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, got, want);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hang guard, far beyond the expected run
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end
  initial begin
    logic [7:0] b, p;
    logic [15:0] ix;
    aepu_opd_t o;
    logic on;
    int k;
    k = $urandom(32'hE2DB9216);
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    // first nine rounds walk every prefix kind with 7F and 80 operands
    for (int i = 0; i < 300; i++) begin
      k = (i < 9) ? i : $urandom % 9;
      p = (i < 9) ? 8'(8'h7F + i % 2) : 8'($urandom);
      b = 8'($urandom);
      ix = 16'($urandom);
      o = aepu_opd_t'(1 + $urandom % 6);
      if (k == 7) iss(mk(AEPU_OP_EXT_LOAD_IMM, AEPU_OPD_NONE, b, b, 4'h0, 4'h0, 16'h0000));
      if (k < 2 || k == 7) ext_m = b;
      if (k != 8) iss(mk(kind[k], AEPU_OPD_NONE, b, b, (k == 7) ? 4'h7 : 4'h8, 4'h8, 16'h0000));
      on = (k < 7);
      iss(mk(AEPU_OP_OTHER, o, p, 8'h00, 4'h0, 4'h0, ix));
      chk(wid(o, p, ext_m, on, ix), on, k == 8);
      iss(mk(AEPU_OP_EXT_READ, AEPU_OPD_NONE, 8'h00, 8'h00, 4'h0, 4'h0, 16'h0000));
      rd_m = ext_m;
      chk(16'h0000, 1'b0, 1'b1);
    end
    end_sim();
  end
endmodule
`default_nettype wire
